// ### hw/mie_top.sv
// Maskable interrupt enable, priority level registers and winner selection
//
// Contract
// - Master enable bit 0 low register gates all maskable sources
// - Each source enable bit gates its source
// - Enables 15..8, 23..16, 25..24 in higher registers
// - Low register: enables 7..4, bits 3..1 zero
// - Acceptance clears master; handler restores it later
// - Two-bit level per source 4..19 overrides basic order
// - Highest programmed level among pending requests wins
// - Equal levels resolved by higher basic priority
// - All levels are zero after reset
// - Level encoding 00 lowest through 11 highest
// - Four fields per byte, highest source top
// - Master and all enables zero after reset
// - Non-maskable requests bypass all enable bits
// - Latch held until accepted; enable n gates n
`timescale 1ns/100ps
module mie_top
  import mie_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  input wire logic [MIE_SRC_LAST:MIE_SRC_FIRST] REQ_LATCH,
  input wire logic [MIE_NMI_COUNT-1:0] NMI_REQ,
  input wire logic IRQ_ACCEPT,
  output logic [7:0] RDATA,
  output logic IRQ_VALID,
  output logic [4:0] IRQ_INDEX,
  output logic NMI_VALID,
  output logic [MIE_SRC_LAST:MIE_SRC_FIRST] LATCH_CLEAR,
  output logic MASTER_ENABLE
);

  mie_state_type state_q; // Registered state
  mie_state_type state_d; // Next state

  // Level of source src; sources without a level register sit at the lowest level
  // Those sources can therefore only win on basic order, never by programming
  function automatic logic [1:0] level_of(input logic [MIE_LVL_COUNT-1:0][1:0] lv,
                                          input int src);
    if (src <= MIE_LVL_LAST) begin
      level_of = lv[src-MIE_SRC_FIRST];
    end else begin
      level_of = MIE_LEVEL_LOWEST;
    end
  endfunction

  // Byte view of a level register: four fields, highest source in bits 7:6
  // Shared by the four level reads so that the packing is written only once
  function automatic logic [7:0] level_byte(input logic [MIE_LVL_COUNT-1:0][1:0] lv,
                                            input int base);
    level_byte = {lv[base+3], lv[base+2], lv[base+1], lv[base]};
  endfunction

  // Working variables of the selector
  logic [MIE_SRC_COUNT-1:0] pending; // Requests that may be accepted now
  logic found; // A candidate has been seen
  logic [1:0] best_level; // Level of the current candidate
  logic [4:0] best_index; // Source number of the current candidate
  logic [4:0] src_num; // Loop source number at five bits

  // Next-state logic: register writes, reads, selection and acceptance
  always_comb begin
    pending = '0;
    found = 1'b0;
    best_level = MIE_LEVEL_LOWEST;
    best_index = 5'h00;
    src_num = 5'h00;
    state_d = state_q;
    state_d.clear = '0;

    // Register writes; the enable registers and levels are plain storage
    // Hardware does not police the software ordering of master against enables
    if (WR_EN) begin
      case (ADDR)
        // Master in bit 0, sources 7..4 on top; bits 3..1 have no storage
        MIE_ADDR_ENABLE_LOW: begin
          state_d.master = WDATA[MIE_MASTER_BIT];
          state_d.enable[3:0] = WDATA[7:MIE_LOW_EN_LSB];
        end
        // Sources 15..8
        MIE_ADDR_ENABLE_HIGH: begin
          state_d.enable[11:4] = WDATA;
        end
        // Sources 23..16
        MIE_ADDR_ENABLE_EXT: begin
          state_d.enable[19:12] = WDATA;
        end
        // Sources 25..24; the upper six bits have no storage
        MIE_ADDR_ENABLE_TOP: begin
          state_d.enable[21:20] = WDATA[MIE_TOP_EN_WIDTH-1:0];
        end
        // Levels of sources 7..4
        MIE_ADDR_LEVEL_A: begin
          state_d.level[3:0] = WDATA;
        end
        // Levels of sources 11..8
        MIE_ADDR_LEVEL_B: begin
          state_d.level[7:4] = WDATA;
        end
        // Levels of sources 15..12
        MIE_ADDR_LEVEL_C: begin
          state_d.level[11:8] = WDATA;
        end
        // Levels of sources 19..16
        MIE_ADDR_LEVEL_D: begin
          state_d.level[15:12] = WDATA;
        end
        default: begin
          // Other addresses belong to other blocks
        end
      endcase
    end

    // Register reads; unused bits return zero, unmapped addresses return zero
    // Reads see the state before the edge, so a same-cycle write shows one read later
    if (RD_EN) begin
      case (ADDR)
        // Unused bits 3..1 read back as zero
        MIE_ADDR_ENABLE_LOW: begin
          state_d.rdata = {state_q.enable[3:0], 3'h0, state_q.master};
        end
        // Sources 15..8
        MIE_ADDR_ENABLE_HIGH: begin
          state_d.rdata = state_q.enable[11:4];
        end
        // Sources 23..16
        MIE_ADDR_ENABLE_EXT: begin
          state_d.rdata = state_q.enable[19:12];
        end
        // Upper six bits read back as zero
        MIE_ADDR_ENABLE_TOP: begin
          state_d.rdata = {6'h00, state_q.enable[21:20]};
        end
        // Levels of sources 7..4
        MIE_ADDR_LEVEL_A: begin
          state_d.rdata = level_byte(state_q.level, 0);
        end
        // Levels of sources 11..8
        MIE_ADDR_LEVEL_B: begin
          state_d.rdata = level_byte(state_q.level, 4);
        end
        // Levels of sources 15..12
        MIE_ADDR_LEVEL_C: begin
          state_d.rdata = level_byte(state_q.level, 8);
        end
        // Levels of sources 19..16
        MIE_ADDR_LEVEL_D: begin
          state_d.rdata = level_byte(state_q.level, 12);
        end
        // Unmapped reads return zero rather than stale data
        default: begin
          state_d.rdata = MIE_RESET_BYTE;
        end
      endcase
    end

    // Pending set: latch n gated by enable n and by the master enable
    // Gating here means a dropped master withdraws the offer on the next edge
    for (int i = 0; i < MIE_SRC_COUNT; i++) begin
      pending[i] = state_q.master && state_q.enable[i] && REQ_LATCH[i+MIE_SRC_FIRST];
    end

    // Walk from the top source down so that a lower index takes an equal level
    // A long compare chain; acceptable at this clock rate and far cheaper than a tree
    for (int i = MIE_SRC_LAST; i >= MIE_SRC_FIRST; i--) begin
      src_num = 5'(i);
      if (pending[i-MIE_SRC_FIRST]) begin
        if (!found || level_of(state_q.level, i) >= best_level) begin
          found = 1'b1;
          best_level = level_of(state_q.level, i);
          best_index = src_num;
        end
      end
    end

    // Winner refreshed every cycle; withdrawn once the master enable drops
    state_d.winner.valid = found;
    state_d.winner.index = best_index;
    state_d.nmi_valid = |NMI_REQ;

    // Acceptance clears the master and the accepted latch; it beats a same-cycle write
    // The offer is withdrawn at once so the core cannot accept the same source twice
    // The clear pulse lasts one cycle; the peripheral latch drops on the edge after
    if (IRQ_ACCEPT && state_q.winner.valid) begin
      state_d.master = 1'b0;
      state_d.winner.valid = 1'b0;
      state_d.clear[state_q.winner.index - 5'(MIE_SRC_FIRST)] = 1'b1;
    end
  end

  // State register; everything starts disabled at the lowest level
  // The reset branch loads constants only, so it stays a plain asynchronous clear
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q.master <= 1'b0;
      state_q.enable <= '0;
      state_q.level <= {MIE_LVL_COUNT{MIE_RESET_LEVEL}};
      state_q.rdata <= MIE_RESET_BYTE;
      state_q.winner <= '0;
      state_q.nmi_valid <= 1'b0;
      state_q.clear <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from the state register
  // No logic after the flops, so the core sees clean, glitch-free levels
  assign RDATA = state_q.rdata;
  assign IRQ_VALID = state_q.winner.valid;
  assign IRQ_INDEX = state_q.winner.index;
  assign NMI_VALID = state_q.nmi_valid;
  assign LATCH_CLEAR = state_q.clear;
  assign MASTER_ENABLE = state_q.master;

endmodule // mie_top

// ### hw/mie_pkg.sv
// Package: register map, field layout and carrier types of the interrupt enable and priority block
package mie_pkg;

  // Register offsets in the special function area
  localparam logic [15:0] MIE_ADDR_ENABLE_LOW = 16'h003A;
  localparam logic [15:0] MIE_ADDR_ENABLE_HIGH = 16'h003B;
  localparam logic [15:0] MIE_ADDR_ENABLE_EXT = 16'h003C;
  localparam logic [15:0] MIE_ADDR_ENABLE_TOP = 16'h003D;
  localparam logic [15:0] MIE_ADDR_LEVEL_A = 16'h0FF0;
  localparam logic [15:0] MIE_ADDR_LEVEL_B = 16'h0FF1;
  localparam logic [15:0] MIE_ADDR_LEVEL_C = 16'h0FF2;
  localparam logic [15:0] MIE_ADDR_LEVEL_D = 16'h0FF3;

  // Source numbering of the maskable requests
  localparam int MIE_SRC_FIRST = 4;
  localparam int MIE_SRC_LAST = 25;
  localparam int MIE_SRC_COUNT = 22;
  localparam int MIE_LVL_LAST = 19;
  localparam int MIE_LVL_COUNT = 16;
  localparam int MIE_NMI_COUNT = 3;

  // Field positions inside the enable registers
  localparam int MIE_MASTER_BIT = 0;
  localparam int MIE_LOW_EN_LSB = 4;
  localparam int MIE_TOP_EN_WIDTH = 2;

  // Reset values
  localparam logic [7:0] MIE_RESET_BYTE = 8'h00;
  localparam logic [1:0] MIE_RESET_LEVEL = 2'h0;

  // Level encoding: larger value wins
  localparam logic [1:0] MIE_LEVEL_LOWEST = 2'h0;
  localparam logic [1:0] MIE_LEVEL_HIGHEST = 2'h3;

  // Winner presented to the sequencer
  typedef struct packed {
    logic valid;
    logic [4:0] index;
  } mie_winner_type;

  // Whole state of the block
  typedef struct packed {
    logic master;
    logic [MIE_SRC_COUNT-1:0] enable;
    logic [MIE_LVL_COUNT-1:0][1:0] level;
    logic [7:0] rdata;
    mie_winner_type winner;
    logic nmi_valid;
    logic [MIE_SRC_COUNT-1:0] clear;
  } mie_state_type;

endpackage

// ### tb/mie_top_assertions.sv
// Checker for the interrupt enable and priority block, bound to its top module
`timescale 1ns/100ps
module mie_top_checker
  import mie_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [15:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  input wire logic [MIE_SRC_LAST:MIE_SRC_FIRST] REQ_LATCH,
  input wire logic [MIE_NMI_COUNT-1:0] NMI_REQ,
  input wire logic IRQ_ACCEPT,
  input wire logic [7:0] RDATA,
  input wire logic IRQ_VALID,
  input wire logic [4:0] IRQ_INDEX,
  input wire logic NMI_VALID,
  input wire logic [MIE_SRC_LAST:MIE_SRC_FIRST] LATCH_CLEAR,
  input wire logic MASTER_ENABLE
);
  logic [MIE_SRC_LAST:MIE_SRC_FIRST] req_q; // Latches one cycle back
  logic wd_q; // Master bit of the last write data
  // Snapshots let the winner be traced back to its cause
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      req_q <= '0;
      wd_q <= 1'b0;
    end else begin
      req_q <= REQ_LATCH;
      wd_q <= WDATA[0];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  AST_GATED: assert property (!MASTER_ENABLE |=> !IRQ_VALID)
    else $error("winner offered with master off");
  AST_MASTER_WR: assert property (WR_EN && ADDR == MIE_ADDR_ENABLE_LOW && !IRQ_ACCEPT
    |=> MASTER_ENABLE == wd_q) else $error("master bit not written");
  AST_ACCEPT: assert property (IRQ_ACCEPT && IRQ_VALID |=> !MASTER_ENABLE && !IRQ_VALID)
    else $error("acceptance left master set");
  AST_CLR_HOT: assert property (IRQ_ACCEPT && IRQ_VALID
    |=> LATCH_CLEAR == (22'h00_0001 << ($past(IRQ_INDEX) - 5'h04))) else $error("wrong clear");
  AST_CLR_PULSE: assert property (|LATCH_CLEAR |=> LATCH_CLEAR == '0)
    else $error("clear longer than one cycle");
  AST_CAUSE: assert property (IRQ_VALID |-> IRQ_INDEX inside {[4:25]} && req_q[IRQ_INDEX]
    && $past(MASTER_ENABLE)) else $error("winner without cause");
  AST_NMI: assert property (1'b1 |=> NMI_VALID == |$past(NMI_REQ))
    else $error("non-maskable request gated");
  AST_LOW_RD: assert property (RD_EN && ADDR == MIE_ADDR_ENABLE_LOW |=> RDATA[3:1] == 3'h0)
    else $error("unused low bits read nonzero");
  AST_RST: assert property (disable iff (1'b0) !RST_B |-> !MASTER_ENABLE && !IRQ_VALID)
    else $error("outputs active in reset");
endmodule // mie_top_checker
bind mie_top mie_top_checker mie_top_checker_inst (.CLK, .RST_B, .ADDR, .WR_EN, .RD_EN, .WDATA,
  .REQ_LATCH, .NMI_REQ, .IRQ_ACCEPT, .RDATA, .IRQ_VALID, .IRQ_INDEX, .NMI_VALID, .LATCH_CLEAR,
  .MASTER_ENABLE);

// ### tb/mie_core_model.sv
// Partner model: peripheral request latches and the core that accepts winners
`timescale 1ns/100ps
module mie_core_model
  import mie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [MIE_SRC_LAST:MIE_SRC_FIRST] set_req,
  input wire logic [MIE_SRC_LAST:MIE_SRC_FIRST] clear_req,
  input wire logic go,
  input wire logic irq_valid,
  output logic [MIE_SRC_LAST:MIE_SRC_FIRST] latch_q,
  output logic accept_q
);
  // Latch holds until cleared; accept pulses once per offer while allowed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= '0;
      accept_q <= 1'b0;
    end else begin
      latch_q <= (latch_q | set_req) & ~clear_req;
      accept_q <= go && irq_valid && !accept_q;
    end
  end
endmodule // mie_core_model

// ### tb/mie_top_tb.sv
// Testbench for the interrupt enable and priority block
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module mie_top_tb import mie_pkg::*; ;
  logic CLK = 0, RST_B = 1, WR_EN = 0, RD_EN = 0, go = 0; // Reset falls just after start
  logic [15:0] ADDR = '0;
  logic [7:0] WDATA = '0;
  logic [2:0] NMI_REQ = '0;
  logic [MIE_SRC_LAST:MIE_SRC_FIRST] set_req = '0, REQ_LATCH, LATCH_CLEAR;
  logic [7:0] RDATA;
  logic [4:0] IRQ_INDEX;
  logic IRQ_VALID, NMI_VALID, MASTER_ENABLE, IRQ_ACCEPT;
  int miscompares = 0, comparisons = 0, cycles = 0;
  logic [15:0] adr [9] = '{16'h003A, 16'h003B, 16'h003C, 16'h003D, 16'h0FF0, 16'h0FF1,
    16'h0FF2, 16'h0FF3, 16'h0040};
  logic [7:0] rbk [9] = '{8'hF0, 8'hFE, 8'hFE, 8'h02, 8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'h00};
  logic [7:0] en [6] = '{8'h0E, 8'h0E, 8'h0E, 8'h0E, 8'h06, 8'h00}; // Enables of sources 15..8
  logic [7:0] lv [6] = '{8'h00, 8'h40, 8'h60, 8'hEC, 8'h40, 8'h40}; // Levels of sources 11..8
  logic [4:0] ix [6] = '{5'h09, 5'h0B, 5'h0A, 5'h09, 5'h09, 5'h14}; // Expected winner
  // Requests: sources 11..9, then 25 and 20, which sit above the level registers
  logic [MIE_SRC_LAST:MIE_SRC_FIRST] rq [6] = '{22'h00_00E0, 22'h00_00E0, 22'h00_00E0,
    22'h00_00E0, 22'h00_00E0, 22'h21_0000};
  always #20 CLK = ~CLK;
  mie_top mie_top_inst (.CLK, .RST_B, .ADDR, .WR_EN, .RD_EN, .WDATA, .REQ_LATCH, .NMI_REQ,
    .IRQ_ACCEPT, .RDATA, .IRQ_VALID, .IRQ_INDEX, .NMI_VALID, .LATCH_CLEAR, .MASTER_ENABLE);
  mie_core_model mie_core_model_inst (.clk(CLK), .rst_b(RST_B), .set_req, .clear_req(LATCH_CLEAR),
    .go, .irq_valid(IRQ_VALID), .latch_q(REQ_LATCH), .accept_q(IRQ_ACCEPT));
  // One-byte write, strobe high for exactly one edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge CLK) {ADDR, WDATA, WR_EN} = {a, d, 1'b1};
    @(negedge CLK) WR_EN = 0;
  endtask
  // One-byte read; data is settled the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge CLK) {ADDR, RD_EN} = {a, 1'b1};
    @(negedge CLK) RD_EN = 0;
    `CHK("rdata", e, RDATA)
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the roughly 155 cycles the run needs
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    // A real falling edge, so the asynchronous reset acts before the first clock edge
    #1 RST_B = 0;
    repeat (20) @(negedge CLK);
    RST_B = 1;
    foreach (adr[i]) rd(adr[i], 8'h00);
    foreach (adr[i]) wr(adr[i], 8'hFE);
    foreach (adr[i]) rd(adr[i], rbk[i]);
    // Master is kept off while enables and levels change
    for (int i = 0; i < 6; i++) begin
      wr(MIE_ADDR_ENABLE_LOW, 8'h00);
      wr(MIE_ADDR_LEVEL_B, lv[i]);
      wr(MIE_ADDR_ENABLE_HIGH, en[i]);
      @(negedge CLK) set_req = rq[i];
      @(negedge CLK) set_req = '0;
      `CHK("gated", 1'b0, IRQ_VALID)
      wr(MIE_ADDR_ENABLE_LOW, 8'h01);
      @(negedge CLK);
      `CHK("winner", {1'b1, ix[i]}, {IRQ_VALID, IRQ_INDEX})
      go = 1;
      repeat (2) @(negedge CLK);
      `CHK("accept", 2'b00, {MASTER_ENABLE, IRQ_VALID})
      `CHK("clear", 22'h00_0001 << (ix[i] - 5'h04), LATCH_CLEAR)
      go = 0;
    end
    NMI_REQ = 3'h4;
    repeat (2) @(negedge CLK);
    `CHK("nmi", 1'b1, NMI_VALID)
    print_verdict();
  end
endmodule // mie_top_tb
